// *** rtl/btsc_pkg.sv ***
// Shared constants and types for the bit-test-skip and call execute block.
// Assumes a 14-bit instruction word and a 13-bit program counter.
`default_nettype none
package btsc_pkg;
  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int INSTR_W = 14;
  localparam int PC_W    = 13;
  localparam int LIT_W   = 11;
  localparam int DATA_W  = 8;
  localparam int LATCH_W = 5;

  // ---------------------------------------------------------------
  // Instruction fields and encodings
  // ---------------------------------------------------------------
  localparam int         SKIP_OPC_HI  = 13;
  localparam int         SKIP_OPC_LO  = 10;
  localparam logic [3:0] SKIP_SET_OPC = 4'h7;
  localparam int         CALL_OPC_HI  = 13;
  localparam int         CALL_OPC_LO  = 11;
  localparam logic [2:0] CALL_OPC     = 3'h4;
  localparam int         BIT_SEL_HI   = 9;
  localparam int         BIT_SEL_LO   = 7;
  localparam int         PAGE_HI      = 4;
  localparam int         PAGE_LO      = 3;
  localparam logic [INSTR_W-1:0] NO_OPERATION = 14'h0000;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;

  // ---------------------------------------------------------------
  // Types and helpers
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    BTSC_RUN = 1'b0,
    BTSC_NOP = 1'b1
  } btsc_state_t;

  // Return address of an instruction: its own address plus one.
  function automatic logic [PC_W-1:0] btsc_next_pc(input logic [PC_W-1:0] pc);
    btsc_next_pc = pc + 13'h0001;
  endfunction
endpackage
`default_nettype wire

// *** rtl/btsc_dec_if.sv ***
// Decoded fields passed from the instruction decoder to the execute logic.
// Assumes both ends sit in the same clock domain.
`default_nettype none
interface btsc_dec_if;
  import btsc_pkg::*;
  logic [INSTR_W-1:0] word;
  logic               isSkipSet;
  logic               isCall;
  logic [2:0]         bitSel;
  logic [LIT_W-1:0]   literal;
  modport decoder (input word, output isSkipSet, output isCall, output bitSel, output literal);
  modport exec    (output word, input isSkipSet, input isCall, input bitSel, input literal);
endinterface
`default_nettype wire

// *** rtl/btsc_decode.sv ***
// Combinational decoder for the bit-test-skip-if-set and call instructions.
// Assumes the word presented is the instruction currently in execute.
`default_nettype none
module btsc_decode
  import btsc_pkg::*;
(
  btsc_dec_if.decoder dec
);
  // ---------------------------------------------------------------
  // Field extraction
  // ---------------------------------------------------------------
  // Opcode compares and field slices; no state is held here.
  always_comb begin
    dec.isSkipSet = (dec.word[SKIP_OPC_HI:SKIP_OPC_LO] == SKIP_SET_OPC);
    dec.isCall    = (dec.word[CALL_OPC_HI:CALL_OPC_LO] == CALL_OPC);
    dec.bitSel    = dec.word[BIT_SEL_HI:BIT_SEL_LO];
    dec.literal   = dec.word[LIT_W-1:0];
  end
endmodule
`default_nettype wire

// *** rtl/btsc_exec.sv ***
// Execute stage for bit-test-skip-if-set and subroutine call.
// Assumes the core presents the fetched word, its address, the file register
// value it addresses and the page latch, all on clk, one instruction cycle per clk.
//
// Notes on behaviour
// RULE1 - Tested bit zero: next instruction runs normally.
// RULE2 - Tested bit one: discard next, execute no_operation.
// RULE3 - Skip takes two cycles, no skip one.
// RULE4 - Call pushes address plus one onto stack.
// RULE5 - Call loads literal low, page latch high.
// RULE6 - Caller keeps literal within zero to 2047.
// RULE7 - Call takes two cycles, second forced no_operation.
`default_nettype none
module btsc_exec
  import btsc_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               instrValid,
  input  wire logic [INSTR_W-1:0] instrWord,
  input  wire logic [PC_W-1:0]    instrPc,
  input  wire logic [DATA_W-1:0]  fileData,
  input  wire logic [LATCH_W-1:0] pcUpperPageLatch,
  output logic      [INSTR_W-1:0] execOp_q,
  output logic                    skipTaken_q,
  output logic                    nopCycle_q,
  output logic                    pushValid_q,
  output logic      [PC_W-1:0]    returnStackTop_q,
  output logic                    pcLoad_q,
  output logic      [PC_W-1:0]    pcTarget_q,
  output logic                    retire_q
);
  // ---------------------------------------------------------------
  // Decoder
  // ---------------------------------------------------------------
  // Decoded fields travel in an interface so further execute units can share
  // the decoder without growing a long port list.
  btsc_dec_if dec ();

  assign dec.word = instrWord;

  btsc_decode u_decode (
    .dec (dec.decoder)
  );

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  btsc_state_t          state_q;
  btsc_state_t          state_d;
  logic [INSTR_W-1:0]   execOp_d;
  logic                 skipTaken_d;
  logic                 nopCycle_d;
  logic                 pushValid_d;
  logic [PC_W-1:0]      returnStackTop_d;
  logic                 pcLoad_d;
  logic [PC_W-1:0]      pcTarget_d;
  logic                 retire_d;
  logic                 testedBit;
  logic                 takeNew;

  // The tested bit is picked straight from the file value; a three-bit select
  // can never point outside the eight data bits.
  assign testedBit = fileData[dec.bitSel];
  assign takeNew   = (state_q == BTSC_RUN) && instrValid;

  // The stack top and target hold their last value so the core may sample
  // them late; the strobes and the executed word are single-cycle.
  always_comb begin
    state_d          = state_q;
    execOp_d         = NO_OPERATION;
    skipTaken_d      = 1'b0;
    nopCycle_d       = 1'b0;
    pushValid_d      = 1'b0;
    returnStackTop_d = returnStackTop_q;
    pcLoad_d         = 1'b0;
    pcTarget_d       = pcTarget_q;
    retire_d         = 1'b0;
    case (state_q)
      BTSC_RUN: begin
        if (instrValid) begin
          execOp_d = instrWord;
          if (dec.isSkipSet && testedBit) begin
            // RULE2 skip discards next
            skipTaken_d = 1'b1;
            state_d     = BTSC_NOP;
          end else if (dec.isCall) begin
            // RULE4 push return address
            pushValid_d      = 1'b1;
            returnStackTop_d = btsc_next_pc(instrPc);
            // RULE5 build call target
            pcLoad_d         = 1'b1;
            pcTarget_d       = {pcUpperPageLatch[PAGE_HI:PAGE_LO], dec.literal};
            state_d          = BTSC_NOP;
          end else begin
            // RULE1 no skip, single cycle
            retire_d = 1'b1;
          end
        end
      end
      BTSC_NOP: begin
        // RULE3 second cycle completes
        // RULE7 forced no_operation cycle
        // Whatever word is fetched now belongs to the old flow and is dropped.
        nopCycle_d = 1'b1;
        retire_d   = 1'b1;
        state_d    = BTSC_RUN;
      end
      default: begin
        state_d = BTSC_RUN;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Every output is registered here, so decisions show one cycle after the
  // word was taken.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q          <= BTSC_RUN;
      execOp_q         <= NO_OPERATION;
      skipTaken_q      <= 1'b0;
      nopCycle_q       <= 1'b0;
      pushValid_q      <= 1'b0;
      returnStackTop_q <= PC_RESET;
      pcLoad_q         <= 1'b0;
      pcTarget_q       <= PC_RESET;
      retire_q         <= 1'b0;
    end else begin
      state_q          <= state_d;
      execOp_q         <= execOp_d;
      skipTaken_q      <= skipTaken_d;
      nopCycle_q       <= nopCycle_d;
      pushValid_q      <= pushValid_d;
      returnStackTop_q <= returnStackTop_d;
      pcLoad_q         <= pcLoad_d;
      pcTarget_q       <= pcTarget_d;
      retire_q         <= retire_d;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // Every check runs on the one instruction clock and is muted while reset is
  // low, so the edges around a release never compare against reset values.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic            skipHit;
  logic            callHit;
  logic            bitHit;
  logic            skipGo;
  logic            skipNo;
  logic            callGo;
  logic            plainGo;
  logic            inSlot;
  logic [PC_W-1:0] callTarget;
  logic [PC_W-1:0] callReturn;

  // Antecedents are rebuilt from the raw word and pins instead of the decoder,
  // so a broken decode cannot hide behind its own wrong answer.
  assign skipHit    = (instrWord[SKIP_OPC_HI:SKIP_OPC_LO] == SKIP_SET_OPC);
  assign callHit    = (instrWord[CALL_OPC_HI:CALL_OPC_LO] == CALL_OPC);
  assign bitHit     = fileData[instrWord[BIT_SEL_HI:BIT_SEL_LO]];
  assign skipGo     = takeNew && skipHit && bitHit;
  assign skipNo     = takeNew && skipHit && !bitHit;
  assign callGo     = takeNew && callHit;
  assign plainGo    = takeNew && !callHit && !(skipHit && bitHit);
  assign inSlot     = (state_q == BTSC_NOP);
  assign callTarget = {pcUpperPageLatch[PAGE_HI:PAGE_LO], instrWord[LIT_W-1:0]};
  assign callReturn = instrPc + 13'h0001;

  a_skip_clear_runs: assert property (skipNo |=> retire_q && !skipTaken_q && !nopCycle_q ##1 !nopCycle_q) // RULE1
    else $error("Clear tested bit did not run the next instruction.");

  a_skip_set_nop: assert property (skipGo |=> skipTaken_q ##1 (nopCycle_q && execOp_q == NO_OPERATION)) // RULE2
    else $error("Set tested bit did not replace the next instruction by a no-op.");

  a_skip_two_cycles: assert property (skipGo |=> !retire_q ##1 retire_q) // RULE3
    else $error("Taken skip did not complete in exactly two cycles.");

  a_call_push_ret: assert property (callGo |=> pushValid_q && returnStackTop_q == $past(callReturn)) // RULE4
    else $error("Call pushed a wrong return address.");

  a_call_pc_target: assert property (callGo |=> pcLoad_q && pcTarget_q == $past(callTarget)) // RULE5
    else $error("Call loaded a wrong program counter.");

  a_call_nop_slot: assert property (callGo |=> !retire_q ##1 // RULE7
    (nopCycle_q && retire_q && !pushValid_q && !pcLoad_q))
    else $error("Call second cycle was not a forced no-op.");

  // The discarded slot must neither act on the word it drops nor last longer
  // than one cycle; a stuck slot would silently freeze the fetch stream.
  a_slot_drops_word: assert property (inSlot |=> execOp_q == NO_OPERATION && // RULE2
    !skipTaken_q && !pushValid_q && !pcLoad_q)
    else $error("Discarded slot acted on the dropped word.");

  a_slot_one_cycle: assert property (inSlot |=> !inSlot) // RULE3
    else $error("Forced no-op slot lasted more than one cycle.");

  a_skip_clear_word: assert property (skipNo |=> execOp_q == $past(instrWord) && !pushValid_q && !pcLoad_q) // RULE1
    else $error("Clear tested bit did not execute as an ordinary instruction.");

  a_plain_one_cycle: assert property (plainGo |=> retire_q && !nopCycle_q && execOp_q == $past(instrWord)) // RULE3
    else $error("Single-cycle instruction did not retire in one cycle.");

  // Stack top and target stand between calls so the core may sample them late.
  a_call_values_hold: assert property (!callGo |=> $stable(returnStackTop_q) && $stable(pcTarget_q)) // RULE4
    else $error("Stack top or call target changed without a call.");

  // Scenarios the bench is expected to reach at least once.
  c_plain_retire: cover property (plainGo ##1 retire_q);
  c_skip_taken: cover property (skipGo ##2 retire_q);
  c_skip_not_taken: cover property (skipNo ##1 retire_q);
  c_call_done: cover property (callGo ##1 pushValid_q ##1 nopCycle_q);
  c_back_to_back: cover property (callGo ##2 skipGo);
endmodule
`default_nettype wire

// *** bench/bit_test_skip_and_call_exec_test.sv ***
// Self-checking bench for the skip-if-set and call execute block.
// Assumes the package and execute module are compiled first; no partner model.
`default_nettype none
module bit_test_skip_and_call_exec_test
  import btsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               instrValid = 1'b0;
  logic [INSTR_W-1:0] instrWord = 14'h0000;
  logic [PC_W-1:0]    instrPc = 13'h0000;
  logic [DATA_W-1:0]  fileData = 8'h00;
  logic [LATCH_W-1:0] pageLatch = 5'h00;
  logic [INSTR_W-1:0] execOp;
  logic               skipTaken, nopCycle, pushValid, pcLoad, retire;
  logic [PC_W-1:0]    stackTop, pcTarget;
  int                 failures = 0;
  int                 comparisons = 0;
  // Words that follow a two-cycle instruction; this one is a plain one-cycle op.
  localparam logic [INSTR_W-1:0] FOLLOW = 14'h0A55;

  btsc_exec u_dut (.clk(clk), .rst_n(rst_n), .instrValid(instrValid), .instrWord(instrWord),
    .instrPc(instrPc), .fileData(fileData), .pcUpperPageLatch(pageLatch), .execOp_q(execOp),
    .skipTaken_q(skipTaken), .nopCycle_q(nopCycle), .pushValid_q(pushValid),
    .returnStackTop_q(stackTop), .pcLoad_q(pcLoad), .pcTarget_q(pcTarget), .retire_q(retire));

  // The clock toggles every half period of 12.5 ns, a 25 ns period.
  initial begin
    forever #12.5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Inputs change on the falling edge so the rising edge samples them cleanly.
  task automatic cyc(input logic v, input logic [13:0] w, input logic [12:0] p, input logic [7:0] d);
    @(negedge clk);
    instrValid = v;
    instrWord = w;
    instrPc = p;
    fileData = d;
  endtask

  task automatic chk(input string name, input logic [13:0] e, input logic [13:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic summarize();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Skip-if-set on bit b; the other bits are the inverse so a wrong bit select shows.
  task automatic skipCase(input logic [2:0] b, input logic one);
    logic [13:0] w;
    w = {4'h7, b, 7'h05};
    cyc(1'b1, w, 13'h0100, one ? (8'h01 << b) : ~(8'h01 << b));
    cyc(1'b1, FOLLOW, 13'h0101, 8'hFF);
    chk("skipTaken", {13'h0, one}, {13'h0, skipTaken});
    chk("execOp", w, execOp);
    chk("retire first", {13'h0, !one}, {13'h0, retire});
    cyc(1'b0, 14'h0000, 13'h0000, 8'h00);
    chk("nopCycle", {13'h0, one}, {13'h0, nopCycle});
    chk("retire second", 14'h0001, {13'h0, retire});
    chk("next op", one ? NO_OPERATION : FOLLOW, execOp);
    cyc(1'b0, 14'h0000, 13'h0000, 8'h00);
  endtask

  // Call with literal k from address p; the word after it must be dropped.
  task automatic callCase(input logic [10:0] k, input logic [12:0] p, input logic [4:0] lat);
    pageLatch = lat;
    cyc(1'b1, {3'h4, k}, p, 8'h00);
    cyc(1'b1, FOLLOW, p + 13'h0001, 8'h00);
    chk("pushValid", 14'h0001, {13'h0, pushValid});
    chk("stackTop", {1'b0, p + 13'h0001}, {1'b0, stackTop});
    chk("pcLoad", 14'h0001, {13'h0, pcLoad});
    chk("pcTarget", {1'b0, lat[4:3], k}, {1'b0, pcTarget});
    chk("call retire first", 14'h0000, {13'h0, retire});
    cyc(1'b0, 14'h0000, 13'h0000, 8'h00);
    chk("call nop", 14'h0001, {13'h0, nopCycle});
    chk("call retire second", 14'h0001, {13'h0, retire});
    chk("call dropped op", NO_OPERATION, execOp);
    chk("push pulse", 14'h0000, {13'h0, pushValid});
    cyc(1'b0, 14'h0000, 13'h0000, 8'h00);
  endtask

  // Call, then a skip, each followed by a word of the other kind that must be dropped.
  task automatic backToBack();
    logic [13:0] s;
    s = {4'h7, 3'h0, 7'h11};
    pageLatch = 5'h00;
    cyc(1'b1, {3'h4, 11'h123}, 13'h0040, 8'h00);
    cyc(1'b1, s, 13'h0041, 8'h01);
    chk("b2b push", 14'h0001, {13'h0, pushValid});
    cyc(1'b1, s, 13'h0123, 8'h01);
    chk("b2b dropped skip", 14'h0000, {13'h0, skipTaken});
    chk("b2b slot op", NO_OPERATION, execOp);
    cyc(1'b1, {3'h4, 11'h055}, 13'h0124, 8'h00);
    chk("b2b skip taken", 14'h0001, {13'h0, skipTaken});
    chk("b2b skip op", s, execOp);
    cyc(1'b0, 14'h0000, 13'h0000, 8'h00);
    chk("b2b dropped call", 14'h0000, {13'h0, pushValid});
    chk("b2b no load", 14'h0000, {13'h0, pcLoad});
    chk("b2b stack holds", {1'b0, 13'h0041}, {1'b0, stackTop});
    chk("b2b nop", 14'h0001, {13'h0, nopCycle});
    cyc(1'b0, 14'h0000, 13'h0000, 8'h00);
    chk("b2b idle", 14'h0000, {13'h0, retire});
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(negedge clk);
    chk("reset execOp", 14'h0000, execOp);
    chk("reset target", 14'h0000, {1'b0, pcTarget});
    rst_n = 1'b1;
    for (int b = 0; b < 8; b++) begin
      skipCase(b[2:0], 1'b0);
      skipCase(b[2:0], 1'b1);
    end
    callCase(11'h000, 13'h1FFF, 5'h1F);
    callCase(11'h7FF, 13'h0123, 5'h08);
    callCase(11'h2A5, 13'h0800, 5'h10);
    backToBack();
    summarize();
  end

  // The run needs about 90 cycles; 2000 leaves ample margin before declaring a hang.
  initial begin
    repeat (2000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
